// >>> tsr_pkg.sv
// How it works
// - Alternating merge: stop A feeds channels in turn.
// - Alternating merge: ready only when both hold results.
// - One short pair, then ordinary spacing before next.
// - Merged channels raise word markers together.
// - Edge-split: rising to A, falling to B.
// - Edge-split: output starts after rise and fall.
// - Index clear returns period counter to zero.
// - Clear held one period; index zero after.
// - Index clear acts only with its pin enable.
// - Stop timed against latest reference edge.
// - Per-channel software enable blocks stop events.
// - One bit selects single-ended inputs; pins still enabled.
// - Stop pin enables also switch output drivers.
// - Word marker covers first 8 bits, MSB first.
// - Word carries reference index, then stop result.
// - Receiver clock looped back; bits tied to it.
// - Serial output runs only when enable bit is 1.
// - Single rate: update on falling returned-clock edge.
// - Double rate: update both edges, common offset.
// - Test pattern: ignore stops, send fixed low bits.
// - Offset code selects -160, 0, +160, +320 ps.
// - Level bit: 0 differential, 1 single-ended.
// - Reference index at most 20 bits.
package tsr_pkg;

    // ----------------------------------------------------------------
    // Field widths and fixed values
    // ----------------------------------------------------------------
    localparam int         IDX_MAX_W   = 20;
    localparam int         RES_MAX_W   = 24;   // Widest stop result or pattern.
    localparam int         WORD_MAX_W  = IDX_MAX_W + RES_MAX_W;
    localparam int         MARK_BITS   = 8;
    localparam int         WIDTH_W     = 5;    // Width field, values 1..24.
    localparam logic [23:0] PAT_INDEX  = 24'hF0CCAA;
    localparam logic [23:0] PAT_RESULT = 24'h0AACF0;

    // Merge modes.
    localparam logic [1:0] MERGE_NONE  = 2'h0;
    localparam logic [1:0] MERGE_ALT   = 2'h1;
    localparam logic [1:0] MERGE_EDGE  = 2'h2;

    // Data-valid offsets in picoseconds, indexed by the offset code.
    localparam int         OFFS_NEG_PS = -160;
    localparam int         OFFS_STEP_PS = 160;

    // Reset values.
    localparam logic       RST_LOW     = 1'b0;

    // Serialiser state codes.
    typedef enum logic [2:0] {
        TSR_IDLE = 3'b001,
        TSR_WAIT = 3'b010,
        TSR_SEND = 3'b100
    } tsr_ser_e;

    // Offset in picoseconds of a code, used by the delay model outside.
    function automatic int tsr_offset_ps(input logic [1:0] code);
        tsr_offset_ps = OFFS_NEG_PS + OFFS_STEP_PS * int'(code);
    endfunction : tsr_offset_ps

endpackage : tsr_pkg

// >>> tsr_buffer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two-entry result buffer with valid and ready on both sides
// ----------------------------------------------------------------
module tsr_buffer
    import tsr_pkg::*;
#(
    parameter int WIDTH = WORD_MAX_W
) (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Filling side.
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;   // Entry 0 is the head.
        logic [1:0]            count; // Words held, 0 to 2.
    } tsr_buf_s;

    tsr_buf_s st;       // Registered state.
    tsr_buf_s next_st;  // Next state.

    // Push and pop in the same cycle keep the count, so a full buffer
    // still accepts while draining; a word offered while full and stalled is lost.
    always_comb begin
        logic push;
        logic pop;
        push    = 1'b0;
        pop     = 1'b0;
        next_st = st;
        pop     = outValid && outReady;
        push    = inValid && (st.count != 2'h2 || pop);
        if (pop) begin
            next_st.mem[0] = st.mem[1];
        end
        if (push) begin
            // Write behind the head after any pop.
            if ((st.count - {1'b0, pop}) == 2'h0) begin
                next_st.mem[0] = inData;
            end else begin
                next_st.mem[1] = inData;
            end
        end
        next_st.count = st.count + {1'b0, push} - {1'b0, pop};
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign inReady  = (st.count != 2'h2);
    assign outValid = (st.count != 2'h0);
    assign outData  = st.mem[0];

endmodule : tsr_buffer

// >>> tsr_serializer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Per-channel word serialiser, clocked from sampled link edges
// ----------------------------------------------------------------
module tsr_serializer
    import tsr_pkg::*;
(
    // Clock and reset.
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Word source.
    input  wire logic                  wordValid,
    output logic                       wordTake,
    input  wire logic [WORD_MAX_W-1:0] word,
    input  wire logic [5:0]            wordBits,
    // Start gate from the merge logic.
    input  wire logic                  startOk,
    // Sampled shift edge of the returned clock.
    input  wire logic                  shiftEdge,
    // Serial pins.
    output logic                       dataOut,
    output logic                       markOut,
    output logic                       busy
);

    typedef struct packed {
        tsr_ser_e              state;
        logic [WORD_MAX_W-1:0] shreg;  // MSB-aligned word being sent.
        logic [5:0]            left;   // Bits still to send.
        logic [5:0]            sent;   // Bits already sent.
        logic                  data;
        logic                  mark;
    } tsr_ser_s;

    tsr_ser_s st;
    tsr_ser_s next_st;

    // Loads a word when allowed, then moves one bit per shift edge.
    always_comb begin
        next_st  = st;
        wordTake = 1'b0;
        unique case (st.state)
            TSR_IDLE: begin
                if (wordValid && startOk) begin
                    wordTake       = 1'b1;
                    next_st.shreg  = word << (6'(WORD_MAX_W) - wordBits);
                    next_st.left   = wordBits;
                    next_st.sent   = 6'h00;
                    next_st.state  = TSR_WAIT;
                end
            end
            TSR_WAIT, TSR_SEND: begin
                if (shiftEdge) begin
                    if (st.left == 6'h00) begin
                        next_st.data  = 1'b0;
                        next_st.mark  = 1'b0;
                        next_st.state = TSR_IDLE;
                    end else begin
                        next_st.data  = st.shreg[WORD_MAX_W-1];
                        next_st.mark  = (st.sent < 6'(MARK_BITS));
                        next_st.shreg = st.shreg << 1;
                        next_st.left  = st.left - 6'h01;
                        next_st.sent  = st.sent + 6'h01;
                        next_st.state = TSR_SEND;
                    end
                end
            end
            default: begin
                next_st = '0;
                next_st.state = TSR_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.state <= TSR_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign dataOut = st.data;
    assign markOut = st.mark;
    assign busy    = (st.state != TSR_IDLE);

endmodule : tsr_serializer

// >>> tsr_stop_router.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Stop routing and serial result output, top level
// ----------------------------------------------------------------
module tsr_stop_router
    import tsr_pkg::*;
#(
    parameter int STOP_GAP = 2  // Ordinary stop spacing in sys_clk cycles.
) (
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // Measurement pins.
    input  wire logic                 stopInputA,
    input  wire logic                 stopInputB,
    input  wire logic                 refClock,
    input  wire logic                 refIndexClear,
    // Configuration bits.
    input  wire logic [1:0]           stopChannelMergeSelect,
    input  wire logic                 indexClearPinOn,
    input  wire logic                 chanASoftOn,
    input  wire logic                 chanBSoftOn,
    input  wire logic                 stopAPinOn,
    input  wire logic                 stopBPinOn,
    input  wire logic                 refclockPinOn,
    input  wire logic                 singleEndedLevels,
    input  wire logic                 serialOutputOn,
    input  wire logic                 doubleRate,
    input  wire logic                 testPatternOn,
    input  wire logic [1:0]           outputValidOffset,
    input  wire logic [WIDTH_W-1:0]   periodCountWidth,
    input  wire logic [WIDTH_W-1:0]   stopResultWidth,
    // Link clock from the receiver.
    input  wire logic                 outputClockIn,
    // Output pins.
    output logic                      outputClockReturn,
    output logic                      serialResultOutA,
    output logic                      serialResultOutB,
    output logic                      wordMarkerA,
    output logic                      wordMarkerB,
    output logic                      driverOnA,
    output logic                      driverOnB,
    output logic                      inputLevelSingle,
    output logic [1:0]                validOffsetCode,
    output logic                      resultsReady
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]            syncA;    // Two-stage synchronisers, one bit each:
        logic [1:0]            syncB;    // index 0 is the first flip-flop.
        logic [1:0]            syncR;
        logic [1:0]            syncC;
        logic [1:0]            syncL;
        logic                  lastA;
        logic                  lastB;
        logic                  lastR;
        logic                  lastL;
        logic [IDX_MAX_W-1:0]  periodCount;  // Reference periods seen.
        logic [23:0]           phase;        // Cycles since last reference edge.
        logic                  turnB;        // Alternate mode: next goes to B.
        logic [7:0]            gap;          // Spacing hold-off counter.
        logic                  pairOpen;     // First pulse of a pair taken.
        logic                  haveA;        // Result held for merged start.
        logic                  haveB;
        logic                  retClk;
        logic                  dataA;
        logic                  dataB;
        logic                  markA;
        logic                  markB;
        logic                  drvA;
        logic                  drvB;
        logic                  ready;
    } tsr_top_s;

    tsr_top_s st;
    tsr_top_s next_st;

    // Channel paths between the parts.
    logic [WORD_MAX_W-1:0] capA, capB, bufDataA, bufDataB;
    logic                  capValidA, capValidB;
    logic                  bufReadyA, bufReadyB;
    logic                  bufValidA, bufValidB;
    logic                  takeA, takeB;
    logic                  serDataA, serDataB, serMarkA, serMarkB;
    logic                  busyA, busyB;
    logic                  shiftEdge;
    logic                  startA, startB;
    logic [5:0]            wordBits;
    logic                  merged;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Packs index then result, right-aligned, each at its width.
    function automatic logic [WORD_MAX_W-1:0] pack_word(
        input logic [23:0]        idx,
        input logic [23:0]        res,
        input logic [WIDTH_W-1:0] iw,
        input logic [WIDTH_W-1:0] rw
    );
        logic [WORD_MAX_W-1:0] mi;
        logic [WORD_MAX_W-1:0] mr;
        mi = (WORD_MAX_W'(1) << iw) - WORD_MAX_W'(1);
        mr = (WORD_MAX_W'(1) << rw) - WORD_MAX_W'(1);
        pack_word = (((WORD_MAX_W'(idx) & mi) << rw) | (WORD_MAX_W'(res) & mr));
    endfunction : pack_word

    assign merged    = (stopChannelMergeSelect != MERGE_NONE);
    assign wordBits  = 6'(periodCountWidth) + 6'(stopResultWidth);
    // Single rate shifts on the falling returned-clock edge; double rate on both.
    assign shiftEdge = doubleRate ? (st.syncL[1] != st.lastL)
                                  : (st.lastL && !st.syncL[1]);

    // Merged channels start only together, once both words wait.
    assign startA = serialOutputOn && stopAPinOn
                    && (!merged || (bufValidB && !busyB));
    assign startB = serialOutputOn && (merged ? stopAPinOn : stopBPinOn)
                    && (!merged || (bufValidA && !busyA));

    // ----------------------------------------------------------------
    // Stop capture, index counting and merging
    // ----------------------------------------------------------------
    // Edges are found from the second synchroniser stage only.
    always_comb begin
        logic stop_input_a, stop_input_b, refOn, clrOn, riseA, fallA, riseB, refEdge, open;
        logic [23:0] idx;
        logic [23:0] res;
        stop_input_a = 1'b0; stop_input_b = 1'b0; refOn = 1'b0; clrOn = 1'b0;
        riseA = 1'b0; fallA = 1'b0; riseB = 1'b0; refEdge = 1'b0; open = 1'b0;
        idx = 24'h000000; res = 24'h000000;
        next_st   = st;
        capA      = '0;
        capB      = '0;
        capValidA = 1'b0;
        capValidB = 1'b0;
        next_st.syncA = {st.syncA[0], stopInputA};
        next_st.syncB = {st.syncB[0], stopInputB};
        next_st.syncR = {st.syncR[0], refClock};
        next_st.syncC = {st.syncC[0], refIndexClear};
        next_st.syncL = {st.syncL[0], outputClockIn};
        stop_input_a = st.syncA[1] && stopAPinOn;
        stop_input_b = st.syncB[1] && stopBPinOn;
        refOn = st.syncR[1] && refclockPinOn;
        clrOn = st.syncC[1] && indexClearPinOn;
        next_st.lastA = stop_input_a;
        next_st.lastB = stop_input_b;
        next_st.lastR = refOn;
        next_st.lastL = st.syncL[1];
        riseA   = stop_input_a && !st.lastA;
        fallA   = !stop_input_a && st.lastA;
        riseB   = stop_input_b && !st.lastB;
        refEdge = refOn && !st.lastR;
        // Reference counting; clear holds the count at zero.
        if (refEdge) begin
            next_st.phase       = 24'h000000;
            next_st.periodCount = clrOn ? '0 : st.periodCount + 1'b1;
        end else begin
            next_st.phase = st.phase + 24'h000001;
        end
        if (clrOn) begin
            next_st.periodCount = '0;
        end
        idx = testPatternOn ? PAT_INDEX : 24'(st.periodCount);
        res = testPatternOn ? PAT_RESULT : st.phase;
        capA = pack_word(idx, res, periodCountWidth, stopResultWidth);
        capB = capA;
        if (st.gap != 8'h00) begin
            next_st.gap = st.gap - 8'h01;
        end
        open = (st.gap == 8'h00) && !testPatternOn;
        // Test pattern: keep both paths full with the fixed words.
        if (testPatternOn) begin
            capValidA = chanASoftOn;
            capValidB = chanBSoftOn && (stopChannelMergeSelect == MERGE_NONE || merged);
        end else begin
            unique case (stopChannelMergeSelect)
                MERGE_ALT: begin
                    // Stops from input A go to A and B in turn.
                    if (riseA && open) begin
                        if (!st.turnB) begin
                            capValidA = chanASoftOn;
                        end else begin
                            capValidB = chanBSoftOn;
                        end
                        next_st.turnB = !st.turnB;
                        // Short spacing allowed inside a pair only.
                        next_st.pairOpen = !st.pairOpen;
                        next_st.gap      = st.pairOpen ? 8'(STOP_GAP) : 8'h00;
                    end
                end
                MERGE_EDGE: begin
                    if (riseA && open) begin
                        capValidA = chanASoftOn;
                    end
                    if (fallA && open) begin
                        capValidB = chanBSoftOn;
                        next_st.gap = 8'(STOP_GAP);
                    end
                end
                default: begin
                    capValidA = riseA && chanASoftOn;
                    capValidB = riseB && chanBSoftOn;
                end
            endcase
        end
        // Merged readiness flag: both channels hold a waiting word.
        next_st.haveA = bufValidA;
        next_st.haveB = bufValidB;
        next_st.ready = merged ? (bufValidA && bufValidB)
                               : (bufValidA || bufValidB);
        // Pin drivers follow the stop pin enables.
        next_st.drvA   = serialOutputOn && stopAPinOn;
        next_st.drvB   = serialOutputOn && (merged ? stopAPinOn : stopBPinOn);
        next_st.retClk = st.syncL[1];
        next_st.dataA  = next_st.drvA && serDataA;
        next_st.dataB  = next_st.drvB && serDataB;
        next_st.markA  = next_st.drvA && serMarkA;
        next_st.markB  = next_st.drvB && serMarkB;
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Channel buffers and serialisers
    // ----------------------------------------------------------------
    // A full buffer drops a new stop unless a word leaves it that cycle, like a full result store.
    tsr_buffer #(.WIDTH(WORD_MAX_W)) bufA (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .inValid  (capValidA),
        .inReady  (bufReadyA),
        .inData   (capA),
        .outValid (bufValidA),
        .outReady (takeA),
        .outData  (bufDataA)
    );

    tsr_buffer #(.WIDTH(WORD_MAX_W)) bufB (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .inValid  (capValidB),
        .inReady  (bufReadyB),
        .inData   (capB),
        .outValid (bufValidB),
        .outReady (takeB),
        .outData  (bufDataB)
    );

    tsr_serializer serA (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .wordValid (bufValidA),
        .wordTake  (takeA),
        .word      (bufDataA),
        .wordBits  (wordBits),
        .startOk   (startA),
        .shiftEdge (shiftEdge),
        .dataOut   (serDataA),
        .markOut   (serMarkA),
        .busy      (busyA)
    );

    tsr_serializer serB (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .wordValid (bufValidB),
        .wordTake  (takeB),
        .word      (bufDataB),
        .wordBits  (wordBits),
        .startOk   (startB),
        .shiftEdge (shiftEdge),
        .dataOut   (serDataB),
        .markOut   (serMarkB),
        .busy      (busyB)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Level select and offset code are plain pass-through flops below.
    logic       levelReg;
    logic [1:0] offsReg;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            levelReg <= RST_LOW;
            offsReg  <= 2'h0;
        end else begin
            levelReg <= singleEndedLevels;
            offsReg  <= outputValidOffset;
        end
    end

    assign outputClockReturn = st.retClk;
    assign serialResultOutA  = st.dataA;
    assign serialResultOutB  = st.dataB;
    assign wordMarkerA       = st.markA;
    assign wordMarkerB       = st.markB;
    assign driverOnA         = st.drvA;
    assign driverOnB         = st.drvB;
    assign inputLevelSingle  = levelReg;
    assign validOffsetCode   = offsReg;
    assign resultsReady      = st.ready;

endmodule : tsr_stop_router

// >>> tsr_stop_router_monitor.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module tsr_stop_router_monitor
    import tsr_pkg::*;
(
    // Watched ports.
    input wire logic       sys_clk, rst_n, outputClockIn, outputClockReturn, singleEndedLevels,
    input wire logic       inputLevelSingle, stopAPinOn, stopBPinOn, driverOnA, driverOnB, doubleRate,
    input wire logic       wordMarkerA, wordMarkerB, serialResultOutA, serialResultOutB,
    input wire logic [1:0] outputValidOffset, validOffsetCode, stopChannelMergeSelect
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // The loop-back lags by two sync flops and one output flop.
    a_clock_loop: assert property ($past(rst_n, 3) |-> outputClockReturn == $past(outputClockIn, 3))
        else $error("clock loop broken");
    a_level_copy: assert property ($past(rst_n) |-> inputLevelSingle == $past(singleEndedLevels))
        else $error("level copy wrong");
    a_offset_copy: assert property ($past(rst_n) |-> validOffsetCode == $past(outputValidOffset))
        else $error("offset copy wrong");
    a_driver_a: assert property ($past(rst_n) && !$past(stopAPinOn) |-> !driverOnA)
        else $error("driver a on while off");
    a_driver_b: assert property ($past(rst_n) && !$past(stopBPinOn) |-> !driverOnB)
        else $error("driver b on while off");
    // Merged channels must frame together, or the receiver pairs wrong words.
    a_merge_marks: assert property (stopChannelMergeSelect != MERGE_NONE && $stable(stopChannelMergeSelect)
        |-> wordMarkerA == wordMarkerB)
        else $error("merged word markers differ");
    // Single rate bits move just after a falling edge.
    a_rate_a: assert property (!doubleRate && $changed({serialResultOutA, wordMarkerA})
        |-> ##[0:3] !outputClockReturn)
        else $error("bit a off falling edge");
    a_rate_b: assert property (!doubleRate && $changed({serialResultOutB, wordMarkerB})
        |-> ##[0:3] !outputClockReturn)
        else $error("bit b off falling edge");
endmodule : tsr_stop_router_monitor
bind tsr_stop_router tsr_stop_router_monitor mon (.*);

// >>> tsr_receiver_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Receiver: supplies the link clock and collects words
// ------------------------------------------------------------
module tsr_receiver_model (
    // Pins and collected word.
    input wire logic       run, rclk, sd, fm,
    input wire logic [5:0] nBits,
    output logic           lclk, got,
    output logic [43:0]    word
);
    logic [5:0] cnt = '0;  // Bits still owed; zero when idle.
    logic       fmLast = '0;
    initial {lclk, got, word} = '0;
    // The clock stands still unless words are wanted.
    always #80 lclk = run ? ~lclk : 1'b0;
    // Sample where single rate bits stand still.
    always @(posedge rclk) begin
        got <= 1'b0;
        if (fm && !fmLast) begin
            word <= {43'h0, sd};
            cnt <= nBits - 6'h01;
        end else if (cnt != 6'h00) begin
            word <= {word[42:0], sd};
            cnt <= cnt - 6'h01;
            got <= (cnt == 6'h01);
        end
        fmLast <= fm;
    end
endmodule : tsr_receiver_model

// >>> tsr_stop_router_tb_top.sv
`timescale 1ns/10ps
module tsr_stop_router_tb_top;
    import tsr_pkg::*;
    logic sys_clk = '0, rst_n = '0, stopInputA = '0, refClock = '0, refIndexClear = '0, run = '0;
    logic chanASoftOn = '0, chanBSoftOn = '0, stopAPinOn = '0, stopBPinOn = '0, singleEndedLevels = '0;
    logic serialOutputOn = '0, testPatternOn = '0, outputClockIn, outputClockReturn, wordMarkerA, wordMarkerB;
    logic serialResultOutA, serialResultOutB, gotA, gotB;
    logic [1:0] stopChannelMergeSelect = '0, outputValidOffset = '0;
    logic [4:0] periodCountWidth = 5'h08, stopResultWidth = 5'h10;
    wire [5:0] nBits = periodCountWidth + stopResultWidth;
    logic [43:0] wA, wB;
    logic [87:0] qA[$], qB[$];  // Mask and expected word.
    int err_total = 0, n_compared = 0, cyc = 0;
    logic [15:0] lfsr = 16'h7AA3;
    tsr_stop_router #(.STOP_GAP(2)) dut (.sys_clk, .rst_n, .stopInputA, .stopInputB(1'b0), .refClock,
        .refIndexClear, .stopChannelMergeSelect, .indexClearPinOn(1'b1), .chanASoftOn, .chanBSoftOn, .stopAPinOn,
        .stopBPinOn, .refclockPinOn(1'b1), .singleEndedLevels, .serialOutputOn, .doubleRate(1'b0), .testPatternOn,
        .outputValidOffset, .periodCountWidth, .stopResultWidth, .outputClockIn, .outputClockReturn,
        .serialResultOutA, .serialResultOutB, .wordMarkerA, .wordMarkerB, .driverOnA(), .driverOnB(),
        .inputLevelSingle(), .validOffsetCode(), .resultsReady());
    tsr_receiver_model rxA (.run, .rclk(outputClockReturn), .sd(serialResultOutA), .fm(wordMarkerA), .nBits,
        .lclk(outputClockIn), .got(gotA), .word(wA));
    tsr_receiver_model rxB (.run, .rclk(outputClockReturn), .sd(serialResultOutB), .fm(wordMarkerB), .nBits,
        .lclk(), .got(gotB), .word(wB));
    always #5 sys_clk = ~sys_clk;
    function automatic logic [15:0] next_lfsr(input logic [15:0] v);
        next_lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : next_lfsr
    task automatic check(input logic [43:0] got, input logic [87:0] note);
        n_compared++;
        if ((got & note[87:44]) !== note[43:0]) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got & note[87:44], note[43:0]);
        end
    endtask : check
    task automatic results();
        $display("mismatches %0d of %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // Compare once the receiver's word settles.
    always @(posedge gotA) #1 if (qA.size() != 0) check(wA, qA.pop_front());
    always @(posedge gotB) #1 if (qB.size() != 0) check(wB, qB.pop_front());
    // Random settings and hang guard.
    always @(negedge sys_clk) begin
        lfsr <= next_lfsr(lfsr);
        {singleEndedLevels, outputValidOffset} <= lfsr[2:0];
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            results();
        end
    end
    initial begin
        logic [43:0] w;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        {stopAPinOn, stopBPinOn, serialOutputOn, chanASoftOn, chanBSoftOn} = '1;
        // Test pattern at random widths, set while drained.
        repeat (3) begin
            {periodCountWidth, stopResultWidth} = {5'h08 + 5'(lfsr[2:0]), 5'h01 + 5'(lfsr[5:3])};
            w = (44'(PAT_INDEX) & ((44'h1 << periodCountWidth) - 44'h1)) << stopResultWidth;
            w = w | (44'(PAT_RESULT) & ((44'h1 << stopResultWidth) - 44'h1));
            repeat (2) qA.push_back({44'hFFFFFFFFFFF, w});
            repeat (2) qB.push_back({44'hFFFFFFFFFFF, w});
            {testPatternOn, run} = '1;
            while (qA.size() != 0 || qB.size() != 0) @(negedge sys_clk);
            testPatternOn = 1'b0;
            repeat (2500) @(negedge sys_clk);
        end
        // Alternating merge after an index clear.
        {stopChannelMergeSelect, periodCountWidth, stopResultWidth} = {MERGE_ALT, 5'h08, 5'h10};
        repeat (6) begin
            refClock = ~refClock;
            repeat (8) @(negedge sys_clk);
        end
        refIndexClear = 1'b1;
        repeat (20) @(negedge sys_clk);
        refIndexClear = 1'b0;
        repeat (2) begin
            qA.push_back({44'hFFFFFFF0000, 44'h0});
            qB.push_back({44'hFFFFFFF0000, 44'h0});
            repeat (2) begin
                stopInputA = 1'b1;
                repeat (3) @(negedge sys_clk);
                stopInputA = 1'b0;
                repeat (3) @(negedge sys_clk);
            end
            repeat (30) @(negedge sys_clk);
        end
        while (qA.size() != 0 || qB.size() != 0) @(negedge sys_clk);
        results();
    end
endmodule : tsr_stop_router_tb_top
